// ===== hw/ssl_pkg.sv
package ssl_pkg;
    // ------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 24;
    localparam int BYTE_W = 8;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_W = 2;
    localparam logic [1:0] ADDR_REF = 2'h0;
    localparam logic [1:0] ADDR_FB = 2'h1;
    localparam logic [1:0] ADDR_FUNC = 2'h2;
    localparam logic [1:0] ADDR_INIT = 2'h3;
    localparam logic [23:0] LATCH_RST = 24'h000000;

    // function latch fields used by the loader
    localparam int FUNC_CP_TRI_BIT = 3;
    localparam int FUNC_MUX_LSB = 4;
    localparam int MUX_W = 3;
    localparam logic [2:0] MUX_LOW = 3'h0;
    localparam logic [2:0] MUX_LOCK = 3'h1;
    localparam logic [2:0] MUX_ACTIVE = 3'h2;
    localparam logic [2:0] MUX_HIGH = 3'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int SCLK_MAX_HZ = 20_000_000;
    // least half period, rounded up
    localparam int SCLK_HALF_CYC = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
    localparam int LE_HIGH_CYC = 2;
    localparam int TIMER_W = 8;
    localparam int BITCNT_W = 5;
endpackage

// ===== hw/ssl_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ssl_link_if;
    logic serial_clk;
    logic serial_in_bit;
    logic latch_strobe;
    logic chip_enable;
    logic muxed_status_out;

    modport dev (
        input serial_clk,
        input serial_in_bit,
        input latch_strobe,
        input chip_enable,
        output muxed_status_out
    );

    modport host (
        output serial_clk,
        output serial_in_bit,
        output latch_strobe,
        output chip_enable,
        input muxed_status_out
    );
endinterface
`default_nettype wire

// ===== hw/ssl_device.sv
`timescale 1ns/1ns
`default_nettype none
module ssl_device (
    input wire logic clk,
    input wire logic rstn,
    ssl_link_if.dev link,
    input wire logic lock_indicator,
    output logic [23:0] ref_latch_q,
    output logic [23:0] fb_latch_q,
    output logic [23:0] func_latch_q,
    output logic load_strobe_q,
    output logic [1:0] load_addr_q,
    output logic counter_reset_q,
    output logic cp_tristate_q,
    output logic output_active_q,
    output logic power_down
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // order: lock, strobe, data, clock
    // chip enable is left out: power-down must not wait for these flops
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [1:0] hist_q;
    logic sclk_rise;
    logic le_rise;

    // the strobe idles high, so its history starts high; a low start would
    // read as a strobe rise just after reset and load a stale word
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1_q <= 4'h4;
            sync2_q <= 4'h4;
            hist_q <= 2'h2;
        end else begin
            sync1_q <= {lock_indicator, link.latch_strobe, link.serial_in_bit, link.serial_clk};
            sync2_q <= sync1_q;
            hist_q <= {sync2_q[2], sync2_q[0]};
        end
    end

    // edges come from the second flop only, so a metastable first stage never reaches logic
    assign sclk_rise = sync2_q[0] & ~hist_q[0];
    assign le_rise = sync2_q[2] & ~hist_q[1];

    // ------------------------------------------------------------
    // input shift register
    // ------------------------------------------------------------
    // nothing is refused: extra bits fall out the top, the last 24 count
    logic [23:0] shift_q, shift_d;

    always_comb begin
        shift_d = shift_q;
        if (sclk_rise) begin
            shift_d = {shift_q[ssl_pkg::WORD_W-2:0], sync2_q[1]};
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            shift_q <= ssl_pkg::LATCH_RST;
        end else begin
            shift_q <= shift_d;
        end
    end

    // ------------------------------------------------------------
    // latches and load sequencing
    // ------------------------------------------------------------
    logic [23:0] ref_latch_d, fb_latch_d, func_latch_d;
    logic load_strobe_d, counter_reset_d, cp_tristate_d, output_active_d;
    logic [1:0] load_addr_d;
    // armed by an init load, spent by the first feedback load after it
    logic fb_reset_armed_q, fb_reset_armed_d;
    logic [2:0] seen_q, seen_d;
    logic [1:0] sel;

    always_comb begin
        ref_latch_d = ref_latch_q;
        fb_latch_d = fb_latch_q;
        func_latch_d = func_latch_q;
        load_addr_d = load_addr_q;
        load_strobe_d = 1'b0;
        counter_reset_d = 1'b0;
        fb_reset_armed_d = fb_reset_armed_q;
        seen_d = seen_q;
        // address bits are the last two shifted in, just before the strobe
        sel = shift_q[ssl_pkg::ADDR_LSB +: ssl_pkg::ADDR_W];
        if (le_rise) begin
            // one-cycle pulse and address let the rest of the chip see each load
            load_strobe_d = 1'b1;
            load_addr_d = sel;
            unique case (sel)
                ssl_pkg::ADDR_REF: begin
                    ref_latch_d = shift_q;
                    seen_d[0] = 1'b1;
                end
                ssl_pkg::ADDR_FB: begin
                    fb_latch_d = shift_q;
                    seen_d[1] = 1'b1;
                    counter_reset_d = fb_reset_armed_q;
                    fb_reset_armed_d = 1'b0;
                end
                ssl_pkg::ADDR_FUNC: begin
                    func_latch_d = shift_q;
                end
                ssl_pkg::ADDR_INIT: begin
                    func_latch_d = shift_q;
                    counter_reset_d = 1'b1;
                    fb_reset_armed_d = 1'b1;
                    seen_d[2] = 1'b1;
                end
            endcase
        end
        // active once all three kinds written
        // sticky: only reset clears the power-up sequence
        output_active_d = &seen_d;
        // charge pump idles during a counter reset as well
        cp_tristate_d = func_latch_d[ssl_pkg::FUNC_CP_TRI_BIT] | counter_reset_d;
    end

    // latches have no power-down path, so contents survive
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ref_latch_q <= ssl_pkg::LATCH_RST;
            fb_latch_q <= ssl_pkg::LATCH_RST;
            func_latch_q <= ssl_pkg::LATCH_RST;
            load_addr_q <= 2'h0;
            load_strobe_q <= 1'b0;
            counter_reset_q <= 1'b0;
            cp_tristate_q <= 1'b0;
            output_active_q <= 1'b0;
            fb_reset_armed_q <= 1'b0;
            seen_q <= 3'h0;
        end else begin
            ref_latch_q <= ref_latch_d;
            fb_latch_q <= fb_latch_d;
            func_latch_q <= func_latch_d;
            load_addr_q <= load_addr_d;
            load_strobe_q <= load_strobe_d;
            counter_reset_q <= counter_reset_d;
            cp_tristate_q <= cp_tristate_d;
            output_active_q <= output_active_d;
            fb_reset_armed_q <= fb_reset_armed_d;
            seen_q <= seen_d;
        end
    end

    // ------------------------------------------------------------
    // multiplexed status output
    // ------------------------------------------------------------
    // registered so the status pin never glitches while the select changes
    logic mux_q, mux_d;
    logic [2:0] mux_sel;

    always_comb begin
        mux_sel = func_latch_q[ssl_pkg::FUNC_MUX_LSB +: ssl_pkg::MUX_W];
        unique case (mux_sel)
            ssl_pkg::MUX_LOCK: mux_d = sync2_q[3];
            ssl_pkg::MUX_ACTIVE: mux_d = output_active_q;
            ssl_pkg::MUX_HIGH: mux_d = 1'b1;
            default: mux_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mux_q <= 1'b0;
        end else begin
            mux_q <= mux_d;
        end
    end

    assign link.muxed_status_out = mux_q;

    // ------------------------------------------------------------
    // power down
    // ------------------------------------------------------------
    // immediate, no clock involved
    // left unregistered on purpose: a flop would add the clock wait
    // latches and shift register ignore chip enable, so programming survives
    // trade-off: the pin reaches logic unsynchronised, glitches pass straight through
    assign power_down = ~link.chip_enable;
endmodule
`default_nettype wire

// ===== hw/ssl_host.sv
`timescale 1ns/1ns
`default_nettype none
module ssl_host #(
    parameter int HALF_CYC = ssl_pkg::SCLK_HALF_CYC,
    parameter int BYTE_GAP_CYC = 0
) (
    input wire logic clk,
    input wire logic rstn,
    ssl_link_if.host link,
    input wire logic cmd_valid,
    input wire logic [23:0] cmd_word,
    output logic cmd_ready_q,
    input wire logic chip_enable_req,
    output logic lock_status_q,
    output logic init_done_q
);
    typedef enum logic [2:0] {
        SSL_IDLE = 3'h0,
        SSL_LOW = 3'h1,
        SSL_HIGH = 3'h2,
        SSL_GAP = 3'h3,
        SSL_TAIL = 3'h4,
        SSL_STROBE = 3'h5
    } ssl_host_state_e;

    // ------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------
    ssl_host_state_e state_q, state_d;
    logic [23:0] word_q, word_d;
    logic [4:0] bits_q, bits_d;
    logic [7:0] timer_q, timer_d;
    logic sclk_q, sclk_d, serial_in_bit_q, serial_in_bit_d, le_q, le_d, ce_q;
    logic [2:0] seen_q, seen_d;
    logic timer_done;

    function automatic logic [7:0] cyc(input int n);
        cyc = 8'(n - 1);
    endfunction

    assign timer_done = (timer_q == 8'h00);

    always_comb begin
        state_d = state_q;
        word_d = word_q;
        bits_d = bits_q;
        timer_d = timer_done ? 8'h00 : timer_q - 8'h01;
        sclk_d = sclk_q;
        serial_in_bit_d = serial_in_bit_q;
        le_d = le_q;
        seen_d = seen_q;
        unique case (state_q)
            SSL_IDLE: begin
                if (cmd_valid) begin
                    le_d = 1'b0;
                    word_d = {cmd_word[22:0], 1'b0};
                    // msb presented while clock is low
                    serial_in_bit_d = cmd_word[23];
                    bits_d = 5'(ssl_pkg::WORD_W - 1);
                    timer_d = cyc(HALF_CYC);
                    state_d = SSL_LOW;
                    unique case (cmd_word[1:0])
                        ssl_pkg::ADDR_REF: seen_d[0] = 1'b1;
                        ssl_pkg::ADDR_FB: seen_d[1] = 1'b1;
                        ssl_pkg::ADDR_INIT: seen_d[2] = 1'b1;
                        default: seen_d = seen_q;
                    endcase
                end
            end
            SSL_LOW: begin
                if (timer_done) begin
                    // half period never under the 20 MHz limit
                    sclk_d = 1'b1;
                    timer_d = cyc(HALF_CYC);
                    state_d = SSL_HIGH;
                end
            end
            SSL_HIGH: begin
                if (timer_done) begin
                    sclk_d = 1'b0;
                    if (bits_q == 5'h00) begin
                        timer_d = cyc(HALF_CYC);
                        state_d = SSL_TAIL;
                    end else begin
                        serial_in_bit_d = word_q[23];
                        word_d = {word_q[22:0], 1'b0};
                        bits_d = bits_q - 5'h01;
                        timer_d = cyc(HALF_CYC);
                        // optional pause at byte boundary, strobe stays low
                        if (BYTE_GAP_CYC > 0 && bits_q[2:0] == 3'h0) begin
                            timer_d = cyc(BYTE_GAP_CYC + HALF_CYC);
                            state_d = SSL_GAP;
                        end else begin
                            state_d = SSL_LOW;
                        end
                    end
                end
            end
            SSL_GAP: begin
                if (timer_done) begin
                    sclk_d = 1'b1;
                    timer_d = cyc(HALF_CYC);
                    state_d = SSL_HIGH;
                end
            end
            SSL_TAIL: begin
                if (timer_done) begin
                    // strobe rises after the third byte
                    le_d = 1'b1;
                    timer_d = cyc(ssl_pkg::LE_HIGH_CYC);
                    state_d = SSL_STROBE;
                end
            end
            SSL_STROBE: begin
                if (timer_done) begin
                    state_d = SSL_IDLE;
                end
            end
            default: state_d = SSL_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= SSL_IDLE;
            word_q <= ssl_pkg::LATCH_RST;
            bits_q <= 5'h00;
            timer_q <= 8'h00;
            sclk_q <= 1'b0;
            serial_in_bit_q <= 1'b0;
            le_q <= 1'b1;
            seen_q <= 3'h0;
        end else begin
            state_q <= state_d;
            word_q <= word_d;
            bits_q <= bits_d;
            timer_q <= timer_d;
            sclk_q <= sclk_d;
            serial_in_bit_q <= serial_in_bit_d;
            le_q <= le_d;
            seen_q <= seen_d;
        end
    end

    // ------------------------------------------------------------
    // side signals
    // ------------------------------------------------------------
    logic lock_s1_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cmd_ready_q <= 1'b0;
            ce_q <= 1'b0;
            lock_s1_q <= 1'b0;
            lock_status_q <= 1'b0;
            init_done_q <= 1'b0;
        end else begin
            cmd_ready_q <= (state_d == SSL_IDLE) && !(state_q == SSL_IDLE && cmd_valid);
            ce_q <= chip_enable_req;
            lock_s1_q <= link.muxed_status_out;
            lock_status_q <= lock_s1_q;
            // counted once the last of the three words is out
            init_done_q <= (state_q == SSL_STROBE) ? &seen_q : init_done_q;
        end
    end

    assign link.serial_clk = sclk_q;
    assign link.serial_in_bit = serial_in_bit_q;
    assign link.latch_strobe = le_q;
    assign link.chip_enable = ce_q;
endmodule
`default_nettype wire

// ===== verification/ssl_link_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module ssl_link_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic serial_clk,
    input wire logic serial_in_bit,
    input wire logic latch_strobe,
    input wire logic chip_enable,
    input wire logic muxed_status_out
);
    // ------------------------------------------------------------
    // rising serial clocks counted while the strobe is low
    // ------------------------------------------------------------
    logic [5:0] bit_cnt_q;
    logic [5:0] bit_cnt_d;
    logic sclk_q;
    logic sclk_d;
    always_comb begin
        sclk_d = serial_clk;
        bit_cnt_d = bit_cnt_q;
        if (latch_strobe) begin
            bit_cnt_d = 6'h00;
        end else if (serial_clk && !sclk_q) begin
            bit_cnt_d = bit_cnt_q + 6'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bit_cnt_q <= 6'h00;
            sclk_q <= 1'b0;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            sclk_q <= sclk_d;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_strobe_sclk_low: assert property (latch_strobe |-> !serial_clk)
        else $error("serial clock high while strobe high");
    chk_shift_setup: assert property ($fell(latch_strobe) |=> !serial_clk)
        else $error("serial clock rose with strobe fall");
    chk_sclk_high_hold: assert property ($rose(serial_clk) |=> serial_clk)
        else $error("serial clock high phase too short");
    chk_sclk_low_hold: assert property ($fell(serial_clk) |=> !serial_clk)
        else $error("serial clock low phase too short");
    chk_data_setup: assert property ($rose(serial_clk) |-> $stable(serial_in_bit))
        else $error("data changed at rising serial clock");
    chk_data_hold: assert property (serial_clk && $past(serial_clk) |-> $stable(serial_in_bit))
        else $error("data changed while serial clock high");
    chk_word_bits: assert property ($rose(latch_strobe) |-> bit_cnt_q == 6'h18)
        else $error("strobe rose after wrong bit count");
    chk_strobe_width: assert property ($rose(latch_strobe) |=> latch_strobe)
        else $error("strobe high pulse too short");
    cover property ($fell(chip_enable));
    cover property ($rose(muxed_status_out));
endmodule
`default_nettype wire

// ===== verification/synth_serial_latch_loader_test.sv
`timescale 1ns/1ns
`default_nettype none
module synth_serial_latch_loader_test;
    logic clk;
    logic rstn;
    logic cmd_valid;
    logic [23:0] cmd_word;
    logic chip_enable_req;
    logic lock_indicator;
    logic cmd_ready_q;
    logic lock_status_q;
    logic init_done_q;
    logic [23:0] ref_latch_q;
    logic [23:0] fb_latch_q;
    logic [23:0] func_latch_q;
    logic load_strobe_q;
    logic [1:0] load_addr_q;
    logic counter_reset_q;
    logic cp_tristate_q;
    logic output_active_q;
    logic power_down;
    logic [23:0] wire_sh;
    logic sclk_prev;
    logic le_prev;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int n_loads;
    int n_resets;
    int last_word;
    // model: latch per address, loaded-address mask, reset pulse armed
    int mdl [4];
    int seen;
    int armed;
    ssl_link_if link_if ();
    ssl_host #(.BYTE_GAP_CYC(4)) i_ssl_host (.clk(clk), .rstn(rstn), .link(link_if.host), .cmd_valid(cmd_valid),
        .cmd_word(cmd_word), .cmd_ready_q(cmd_ready_q), .chip_enable_req(chip_enable_req),
        .lock_status_q(lock_status_q), .init_done_q(init_done_q));
    ssl_device i_ssl_device (.clk(clk), .rstn(rstn), .link(link_if.dev), .lock_indicator(lock_indicator),
        .ref_latch_q(ref_latch_q), .fb_latch_q(fb_latch_q), .func_latch_q(func_latch_q),
        .load_strobe_q(load_strobe_q), .load_addr_q(load_addr_q), .counter_reset_q(counter_reset_q),
        .cp_tristate_q(cp_tristate_q), .output_active_q(output_active_q), .power_down(power_down));
    ssl_link_asserts u_chk (.clk(clk), .rstn(rstn), .serial_clk(link_if.serial_clk),
        .serial_in_bit(link_if.serial_in_bit), .latch_strobe(link_if.latch_strobe),
        .chip_enable(link_if.chip_enable), .muxed_status_out(link_if.muxed_status_out));
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (n_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            test_done();
        end
    end
    // wire monitor rebuilds each word as the device should see it
    always @(posedge clk) begin
        sclk_prev <= link_if.serial_clk;
        le_prev <= link_if.latch_strobe;
        if (link_if.serial_clk && !sclk_prev) wire_sh <= {wire_sh[22:0], link_if.serial_in_bit};
        if (rstn && link_if.latch_strobe && le_prev === 1'b0) check(wire_sh, 24'(last_word));
        if (load_strobe_q === 1'b1) n_loads++;
        if (counter_reset_q === 1'b1) n_resets++;
        if (counter_reset_q === 1'b1) check(cp_tristate_q, 24'h000001);
    end
    function automatic logic mux_exp();
        logic [2:0] sel;
        sel = 3'(mdl[2] >> ssl_pkg::FUNC_MUX_LSB);
        case (sel)
            ssl_pkg::MUX_LOCK: return lock_indicator;
            ssl_pkg::MUX_ACTIVE: return (seen & 11) == 11;
            ssl_pkg::MUX_HIGH: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    task automatic check_state();
        check(ref_latch_q, 24'(mdl[0]));
        check(fb_latch_q, 24'(mdl[1]));
        check(func_latch_q, 24'(mdl[2]));
        check(output_active_q, 24'((seen & 11) == 11));
        check(init_done_q, 24'((seen & 11) == 11));
        check(cp_tristate_q, 24'(mdl[2][ssl_pkg::FUNC_CP_TRI_BIT]));
        check(lock_status_q, 24'(mux_exp()));
        check(power_down, 24'(!chip_enable_req));
    endtask
    task automatic send(input logic [1:0] a, input logic [2:0] mux);
        logic [23:0] w;
        int k;
        int exp_rst;
        w = 24'($urandom);
        if (a[1]) w[6:4] = mux;
        w[1:0] = a;
        exp_rst = (a == ssl_pkg::ADDR_INIT || (a == ssl_pkg::ADDR_FB && armed == 1)) ? 1 : 0;
        @(posedge clk);
        lock_indicator <= 1'($urandom);
        cmd_valid <= 1'b1;
        cmd_word <= w;
        last_word = w;
        n_loads = 0;
        n_resets = 0;
        @(posedge clk);
        cmd_valid <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        for (k = 0; k < 1000 && cmd_ready_q !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        repeat (10) @(posedge clk);
        #1;
        if (a == ssl_pkg::ADDR_INIT) mdl[2] = w;
        if (a == ssl_pkg::ADDR_FB) armed = 0;
        if (a == ssl_pkg::ADDR_INIT) armed = 1;
        mdl[a] = w;
        seen |= 1 << a;
        check(24'(n_loads), 24'h000001);
        check(load_addr_q, a);
        check(24'(n_resets), 24'(exp_rst));
        check_state();
    endtask
    initial begin
        rstn = 1'b0;
        cmd_valid = 1'b0;
        cmd_word = 24'h000000;
        chip_enable_req = 1'b1;
        lock_indicator = 1'b0;
        mdl = '{0, 0, 0, 0};
        seen = 0;
        armed = 0;
        void'($urandom(79));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check_state();
        send(ssl_pkg::ADDR_INIT, ssl_pkg::MUX_ACTIVE);
        send(ssl_pkg::ADDR_REF, 3'h0);
        send(ssl_pkg::ADDR_FB, 3'h0);
        send(ssl_pkg::ADDR_FB, 3'h0);
        for (int m = 0; m < 4; m++) send(ssl_pkg::ADDR_FUNC, 3'(m));
        for (int i = 0; i < 12; i++) send(2'($urandom), 3'($urandom));
        // power down keeps latches, then loads resume
        @(posedge clk);
        chip_enable_req <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check_state();
        @(posedge clk);
        chip_enable_req <= 1'b1;
        send(ssl_pkg::ADDR_REF, 3'h0);
        // second reset mid-run clears everything
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        mdl = '{0, 0, 0, 0};
        seen = 0;
        armed = 0;
        repeat (3) @(posedge clk);
        #1;
        check_state();
        send(ssl_pkg::ADDR_INIT, ssl_pkg::MUX_HIGH);
        test_done();
    end
endmodule
`default_nettype wire
